// ===== core/htss_defines.svh
// Register indices, field positions and reset values for the hot-event stamp
// Assumes one include per compile unit; the guard protects against repeats
`ifndef HTSS_DEFINES_SVH
`define HTSS_DEFINES_SVH

// Register indices, byte address is four times the index
`define HTSS_IDX_SEC    8'h20
`define HTSS_IDX_MIN    8'h21
`define HTSS_IDX_CTRL   8'h30
`define HTSS_IDX_LIMIT  8'h31
`define HTSS_IDX_STAT   8'h32

// Control fields
`define HTSS_CTRL_EN    0
`define HTSS_CTRL_LAST  1
`define HTSS_CTRL_CLR   2

// Status fields
`define HTSS_STAT_HOT   0
`define HTSS_STAT_HELD  1

// Reset values and masks
`define HTSS_STAMP_RST  8'h00
`define HTSS_STAMP_MASK 8'h7F
`define HTSS_CTRL_RST   8'h00
`define HTSS_LIMIT_RST  8'h7F

// Temperature slice compared to the limit
`define HTSS_TEMP_HI    11
`define HTSS_TEMP_LO    4

// AXI responses
`define HTSS_RESP_OKAY  2'h0
`define HTSS_RESP_SLV   2'h2

`endif

// ===== core/htss_hot_detect.sv
// Over-temperature comparator with rising-edge event pulse
// Assumes temperature comes from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "htss_defines.svh"

module htss_hot_detect #(
  parameter int TW = 12
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [TW-1:0] temp,
  input  wire logic [7:0]    limit,
  output logic               above,
  output logic               event_p
);

  logic above_d;
  logic above_q;

  // Compare upper temperature bits to the limit
  always_comb begin
    above_d = (temp[`HTSS_TEMP_HI:`HTSS_TEMP_LO] > limit);
  end

  // Register the comparison
  always_ff @(posedge clk) begin
    if (!nrst) begin
      above_q <= 1'b0;
    end else begin
      above_q <= above_d;
    end
  end

  // Event on each crossing into the hot zone
  assign event_p = above_d & ~above_q;
  assign above   = above_q;

endmodule : htss_hot_detect
`default_nettype wire

// ===== core/htss_pkg.sv
// Types shared by the hot-event stamp block
// Assumes the defines header supplies all numeric constants
`default_nettype none

package htss_pkg;

  // Read channel states, one-hot
  typedef enum logic [1:0] {
    HTSS_RD_IDLE = 2'h1,
    HTSS_RD_RESP = 2'h2
  } htss_rd_state_t;

  // Decoded register selector
  typedef struct packed {
    logic       hit;
    logic [7:0] idx;
  } htss_sel_t;

endpackage : htss_pkg

`default_nettype wire

// ===== core/htss_stamp_reg.sv
// One BCD stamp register with capture and clear
// Assumes capture and clear are single-cycle strobes on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "htss_defines.svh"

module htss_stamp_reg (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       capture,
  input  wire logic       clear,
  input  wire logic [7:0] din,
  output logic      [7:0] q
);

  logic [7:0] q_d;
  logic [7:0] q_q;

  // Capture beats clear so a coincident event is kept
  always_comb begin
    q_d = q_q;
    if (capture) begin
      q_d = din & `HTSS_STAMP_MASK;
    end else if (clear) begin
      q_d = `HTSS_STAMP_RST;
    end
  end

  // Stamp storage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_q <= `HTSS_STAMP_RST;
    end else begin
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule : htss_stamp_reg
`default_nettype wire

// ===== core/htss_top.sv
// Hot-event time stamp, seconds and minutes, with AXI4-Lite registers
// Assumes TEMP, TIME_SEC and TIME_MIN come from logic on CLK
//
// Summary of operation
// - Seconds stamp is BCD, bit 7 zero
// - Minutes stamp is BCD, bit 7 zero
// - Stamp registers ignore all bus writes
// - Capture only when enabled; first or last
// - Writing clear bit zeroes both stamps unless a capture lands in the same cycle
// - Event when temperature bits 11:4 exceed limit
`timescale 1ns/10ps
`default_nettype none
`include "htss_defines.svh"

module htss_top #(
  parameter int AW = 10,
  parameter int TW = 12
) (
  input  wire logic          CLK,
  input  wire logic          NRST,
  input  wire logic [TW-1:0] TEMP,
  input  wire logic [7:0]    TIME_SEC,
  input  wire logic [7:0]    TIME_MIN,
  output logic               HOT_NOW,
  input  wire logic [AW-1:0] AWADDR,
  input  wire logic          AWVALID,
  output logic               AWREADY,
  input  wire logic [31:0]   WDATA,
  input  wire logic [3:0]    WSTRB,
  input  wire logic          WVALID,
  output logic               WREADY,
  output logic [1:0]         BRESP,
  output logic               BVALID,
  input  wire logic          BREADY,
  input  wire logic [AW-1:0] ARADDR,
  input  wire logic          ARVALID,
  output logic               ARREADY,
  output logic [31:0]        RDATA,
  output logic [1:0]         RRESP,
  output logic               RVALID,
  input  wire logic          RREADY
);

  // Decode a byte address into a register index
  function automatic htss_pkg::htss_sel_t decode(input logic [AW-1:0] a);
    htss_pkg::htss_sel_t s;
    s.idx = a[9:2];
    s.hit = (a[1:0] == 2'h0) && ((s.idx == `HTSS_IDX_SEC) ||
            (s.idx == `HTSS_IDX_MIN) || (s.idx == `HTSS_IDX_CTRL) ||
            (s.idx == `HTSS_IDX_LIMIT) || (s.idx == `HTSS_IDX_STAT));
    return s;
  endfunction : decode

  logic [7:0] stamp_sec;
  logic [7:0] stamp_min;
  logic       hot_above;
  logic       hot_event;
  logic       capture;
  logic       clear_p;
  logic       held_d;
  logic       held_q;
  logic [7:0] ctrl_d;
  logic [7:0] ctrl_q;
  logic [7:0] limit_d;
  logic [7:0] limit_q;

  // Write channel state
  logic          aw_hold_d;
  logic          aw_hold_q;
  logic [AW-1:0] aw_addr_d;
  logic [AW-1:0] aw_addr_q;
  logic          w_hold_d;
  logic          w_hold_q;
  logic [31:0]   w_data_d;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_d;
  logic [3:0]    w_strb_q;
  logic          bvalid_d;
  logic          bvalid_q;
  logic [1:0]    bresp_d;
  logic [1:0]    bresp_q;
  logic          do_write;
  htss_pkg::htss_sel_t wsel;

  // Read channel state
  htss_pkg::htss_rd_state_t rd_state_d;
  htss_pkg::htss_rd_state_t rd_state_q;
  logic [31:0]   rdata_d;
  logic [31:0]   rdata_q;
  logic [1:0]    rresp_d;
  logic [1:0]    rresp_q;
  htss_pkg::htss_sel_t rsel;

  // Over-temperature detection
  htss_hot_detect #(
    .TW (TW)
  ) u_detect (
    .clk     (CLK),
    .nrst    (NRST),
    .temp    (TEMP),
    .limit   (limit_q),
    .above   (hot_above),
    .event_p (hot_event)
  );

  // Capture gate: enabled, and last mode or nothing held
  assign capture = hot_event & ctrl_q[`HTSS_CTRL_EN] &
                   (ctrl_q[`HTSS_CTRL_LAST] | ~held_q);

  // Seconds and minutes stamps share one capture strobe
  htss_stamp_reg u_sec (
    .clk     (CLK),
    .nrst    (NRST),
    .capture (capture),
    .clear   (clear_p),
    .din     (TIME_SEC),
    .q       (stamp_sec)
  );

  htss_stamp_reg u_min (
    .clk     (CLK),
    .nrst    (NRST),
    .capture (capture),
    .clear   (clear_p),
    .din     (TIME_MIN),
    .q       (stamp_min)
  );

  // Held flag, set wins over clear
  always_comb begin
    held_d = held_q;
    if (capture) begin
      held_d = 1'b1;
    end else if (clear_p) begin
      held_d = 1'b0;
    end
  end

  // Write channel next values
  always_comb begin
    wsel      = decode(aw_addr_q);
    do_write  = aw_hold_q & w_hold_q & ~bvalid_q;
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    ctrl_d    = ctrl_q;
    limit_d   = limit_q;
    clear_p   = 1'b0;
    if (AWVALID && AWREADY) begin
      aw_hold_d = 1'b1;
      aw_addr_d = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_hold_d = 1'b1;
      w_data_d = WDATA;
      w_strb_d = WSTRB;
    end
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wsel.hit ? `HTSS_RESP_OKAY : `HTSS_RESP_SLV;
      if (wsel.hit && w_strb_q[0]) begin
        // Stamp and status indices fall through untouched
        case (wsel.idx)
          `HTSS_IDX_CTRL: begin
            ctrl_d                 = w_data_q[7:0];
            ctrl_d[`HTSS_CTRL_CLR] = 1'b0;
            clear_p = w_data_q[`HTSS_CTRL_CLR];
          end
          `HTSS_IDX_LIMIT: begin
            limit_d = w_data_q[7:0];
          end
          default: begin
            ctrl_d = ctrl_q;
          end
        endcase
      end
    end
    if (bvalid_q && BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  // Write channel and control registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `HTSS_RESP_OKAY;
      ctrl_q    <= `HTSS_CTRL_RST;
      limit_q   <= `HTSS_LIMIT_RST;
      held_q    <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      ctrl_q    <= ctrl_d;
      limit_q   <= limit_d;
      held_q    <= held_d;
    end
  end

  // Read channel next values
  always_comb begin
    rsel       = decode(ARADDR);
    rd_state_d = rd_state_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    case (rd_state_q)
      htss_pkg::HTSS_RD_IDLE: begin
        if (ARVALID) begin
          rd_state_d = htss_pkg::HTSS_RD_RESP;
          rdata_d    = 32'h0000_0000;
          rresp_d    = rsel.hit ? `HTSS_RESP_OKAY : `HTSS_RESP_SLV;
          case (rsel.idx)
            `HTSS_IDX_SEC:   rdata_d[7:0] = stamp_sec;
            `HTSS_IDX_MIN:   rdata_d[7:0] = stamp_min;
            `HTSS_IDX_CTRL:  rdata_d[7:0] = ctrl_q;
            `HTSS_IDX_LIMIT: rdata_d[7:0] = limit_q;
            `HTSS_IDX_STAT: begin
              rdata_d[`HTSS_STAT_HOT]  = hot_above;
              rdata_d[`HTSS_STAT_HELD] = held_q;
            end
            default: rdata_d = 32'h0000_0000;
          endcase
          if (!rsel.hit) begin
            rdata_d = 32'h0000_0000;
          end
        end
      end
      htss_pkg::HTSS_RD_RESP: begin
        if (RREADY) begin
          rd_state_d = htss_pkg::HTSS_RD_IDLE;
        end
      end
      default: begin
        rd_state_d = htss_pkg::HTSS_RD_IDLE;
      end
    endcase
  end

  // Read channel registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rd_state_q <= htss_pkg::HTSS_RD_IDLE;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= `HTSS_RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
    end
  end

  // Bus outputs
  assign AWREADY = ~aw_hold_q & ~bvalid_q;
  assign WREADY  = ~w_hold_q & ~bvalid_q;
  assign BVALID  = bvalid_q;
  assign BRESP   = bresp_q;
  assign ARREADY = (rd_state_q == htss_pkg::HTSS_RD_IDLE);
  assign RVALID  = (rd_state_q == htss_pkg::HTSS_RD_RESP);
  assign RDATA   = rdata_q;
  assign RRESP   = rresp_q;
  assign HOT_NOW = hot_above;

  // Checks on the stamp, hot detection and write response behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sec_bit_seven_a: assert property (stamp_sec[7] == 1'b0)
    else $error("seconds stamp bit 7 set");

  min_bit_seven_a: assert property (stamp_min[7] == 1'b0)
    else $error("minutes stamp bit 7 set");

  ro_stamp_a: assert property (
    do_write && wsel.hit && (wsel.idx == `HTSS_IDX_SEC || wsel.idx == `HTSS_IDX_MIN) && !capture
    |=> $stable(stamp_sec) && $stable(stamp_min))
    else $error("stamp changed by a bus write");

  gate_off_a: assert property (
    !ctrl_q[`HTSS_CTRL_EN] && !clear_p |=> $stable(stamp_sec) && $stable(stamp_min))
    else $error("stamp changed while disabled");

  first_keep_a: assert property (
    held_q && !ctrl_q[`HTSS_CTRL_LAST] && !clear_p
    |=> $stable(stamp_sec) && $stable(stamp_min) && held_q)
    else $error("first stamp overwritten");

  clear_zero_a: assert property (
    clear_p && !capture |=> stamp_sec == `HTSS_STAMP_RST && stamp_min == `HTSS_STAMP_RST && !held_q)
    else $error("clear did not zero stamps");

  detect_a: assert property (
    $rose(hot_above) |-> $past(hot_event) && $past(TEMP[`HTSS_TEMP_HI:`HTSS_TEMP_LO]) > $past(limit_q))
    else $error("hot level without matching event");

  coherent_a: assert property (
    capture |=> stamp_sec == ($past(TIME_SEC) & `HTSS_STAMP_MASK)
            && stamp_min == ($past(TIME_MIN) & `HTSS_STAMP_MASK))
    else $error("stamps not captured together");

  bresp_time_a: assert property (
    do_write |=> BVALID && ((BRESP == `HTSS_RESP_OKAY) == $past(wsel.hit)))
    else $error("write answer missing or wrong");

  // Main scenarios
  cap_first_c: cover property (capture && !held_q);
  cap_last_c:  cover property (capture && held_q);
  clear_c:     cover property (clear_p ##1 capture);
  rd_stamp_c:  cover property (ARVALID && ARREADY && rsel.idx == `HTSS_IDX_SEC);

endmodule : htss_top
`default_nettype wire

// ===== verif/test_high_temp_stamp_sec_min.sv
// Self-checking bench for the hot-event time stamp with AXI4-Lite registers
// Assumes the core files and htss_defines.svh are on the include path
`timescale 1ns/10ps
`default_nettype none
`include "htss_defines.svh"

module test_high_temp_stamp_sec_min;
  logic        CLK = 1'b0, NRST = 1'b0;
  logic [11:0] TEMP = 12'h000;
  logic [7:0]  TIME_SEC = 8'h00, TIME_MIN = 8'h00;
  logic        HOT_NOW, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [9:0]  AWADDR = 10'h000, ARADDR = 10'h000;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0]  WSTRB = 4'h0;
  logic [3:0]  strb_use = 4'hF;
  logic [1:0]  BRESP, RRESP;
  int          fails = 0;
  int          n_compared = 0;

  htss_top #(.AW(10), .TW(12)) uut (
    .CLK(CLK), .NRST(NRST), .TEMP(TEMP), .TIME_SEC(TIME_SEC), .TIME_MIN(TIME_MIN),
    .HOT_NOW(HOT_NOW), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
  );

  // 10 MHz clock
  always #50 CLK = ~CLK;

  // Verdict and end of run
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // One comparison, counted
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Write cycle; handshakes judged on values settled before the edge
  task axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n; logic a, w, b; logic [1:0] r;
    @(posedge CLK);
    AWADDR <= {idx, 2'h0}; AWVALID <= 1'b1; WDATA <= {24'h0, d}; WSTRB <= strb_use;
    WVALID <= 1'b1; BREADY <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge CLK); a = AWVALID & AWREADY; w = WVALID & WREADY; b = BVALID; r = BRESP;
      @(posedge CLK);
      if (a) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (b) break;
    end
    BREADY <= 1'b0;
    if (n == 40) fails++;
    chk({30'h0, r}, {30'h0, er});
  endtask : axi_wr

  // Read cycle with data and response check
  task axi_rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
    int n; logic a, v; logic [31:0] d; logic [1:0] r;
    @(posedge CLK);
    ARADDR <= {idx, 2'h0}; ARVALID <= 1'b1; RREADY <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge CLK); a = ARVALID & ARREADY; v = RVALID; d = RDATA; r = RRESP;
      @(posedge CLK);
      if (a) ARVALID <= 1'b0;
      if (v) break;
    end
    RREADY <= 1'b0;
    if (n == 40) fails++;
    chk(d, {24'h0, ed});
    chk({30'h0, r}, {30'h0, er});
  endtask : axi_rd

  // Temperature step with the running time shown beside it
  task heat(input logic [11:0] t, input logic [7:0] s, input logic [7:0] m);
    @(posedge CLK);
    TEMP <= t; TIME_SEC <= s; TIME_MIN <= m;
    repeat (3) @(posedge CLK);
  endtask : heat

  // Stamps and limit after reset
  task t_reset;
    axi_rd(`HTSS_IDX_SEC, 8'h00, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_MIN, 8'h00, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_LIMIT, `HTSS_LIMIT_RST, `HTSS_RESP_OKAY);
  endtask : t_reset

  // Unmapped place between the stamps and the control register
  task t_unmapped;
    axi_rd(8'h22, 8'h00, `HTSS_RESP_SLV);
    axi_wr(8'h22, 8'h55, `HTSS_RESP_SLV);
    // Write with byte 0 strobe off leaves the limit alone
    strb_use = 4'h0;
    axi_wr(`HTSS_IDX_LIMIT, 8'h12, `HTSS_RESP_OKAY);
    strb_use = 4'hF;
    axi_rd(`HTSS_IDX_LIMIT, `HTSS_LIMIT_RST, `HTSS_RESP_OKAY);
  endtask : t_unmapped

  // First mode: limit boundary, bit 7 masking, later event ignored
  task t_first;
    axi_wr(`HTSS_IDX_LIMIT, 8'h40, `HTSS_RESP_OKAY);
    axi_wr(`HTSS_IDX_CTRL, 8'h01, `HTSS_RESP_OKAY);
    heat(12'h40F, 8'h11, 8'h22);
    axi_rd(`HTSS_IDX_SEC, 8'h00, `HTSS_RESP_OKAY);
    heat(12'h410, 8'hD9, 8'hB7);
    chk({31'h0, HOT_NOW}, 32'h1);
    axi_rd(`HTSS_IDX_SEC, 8'h59, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_MIN, 8'h37, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_STAT, 8'h03, `HTSS_RESP_OKAY);
    heat(12'h000, 8'h01, 8'h02);
    heat(12'h7F0, 8'h05, 8'h06);
    axi_rd(`HTSS_IDX_SEC, 8'h59, `HTSS_RESP_OKAY);
    heat(12'h000, 8'h00, 8'h00);
  endtask : t_first

  // Writes to the stamps are accepted but change nothing
  task t_readonly;
    axi_wr(`HTSS_IDX_SEC, 8'h12, `HTSS_RESP_OKAY);
    axi_wr(`HTSS_IDX_MIN, 8'h34, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_SEC, 8'h59, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_MIN, 8'h37, `HTSS_RESP_OKAY);
  endtask : t_readonly

  // Last mode: each event overwrites
  task t_last;
    axi_wr(`HTSS_IDX_CTRL, 8'h03, `HTSS_RESP_OKAY);
    heat(12'h410, 8'h45, 8'h12);
    axi_rd(`HTSS_IDX_SEC, 8'h45, `HTSS_RESP_OKAY);
    heat(12'h000, 8'h00, 8'h00);
    heat(12'h420, 8'h58, 8'h13);
    axi_rd(`HTSS_IDX_SEC, 8'h58, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_MIN, 8'h13, `HTSS_RESP_OKAY);
    heat(12'h000, 8'h00, 8'h00);
  endtask : t_last

  // Clear zeroes both, then a disabled event leaves them at zero
  task t_clear_disabled;
    axi_wr(`HTSS_IDX_CTRL, 8'h06, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_SEC, 8'h00, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_MIN, 8'h00, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_CTRL, 8'h02, `HTSS_RESP_OKAY);
    heat(12'h7F0, 8'h21, 8'h43);
    axi_rd(`HTSS_IDX_SEC, 8'h00, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_MIN, 8'h00, `HTSS_RESP_OKAY);
    axi_rd(`HTSS_IDX_STAT, 8'h01, `HTSS_RESP_OKAY);
  endtask : t_clear_disabled

  // Main sequence
  initial begin
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    t_reset;
    t_unmapped;
    t_first;
    t_readonly;
    t_last;
    t_clear_disabled;
    stop_test;
  end

  // Watchdog, far beyond the expected run of about 140 cycles
  initial begin
    #(20000 * 100);
    fails++;
    stop_test;
  end
endmodule : test_high_temp_stamp_sec_min

`default_nettype wire
